// ==== core/csl_pkg.sv ====
// constants shared by the clock stop and strap latch block
// assumes a single 200 MHz system clock from which all output clocks are divided
package csl_pkg;

  // ----------------------------------------------------------------
  // clock and sizes
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned NUM_HOST = 4;
  localparam int unsigned NUM_PCI = 6;
  localparam int unsigned NUM_DUAL = 5;

  // ----------------------------------------------------------------
  // half periods in system cycles
  // ----------------------------------------------------------------
  localparam logic [1:0] HOST_HALF_LAST = 2'h1;  // host half period 2 cycles, 50 MHz
  localparam logic [1:0] PCI_HALF_LAST = 2'h2;   // pci half period 3 cycles, 33.3 MHz
  localparam logic [3:0] DUAL_HALF_LAST_HI = 4'h4;  // strap 1: half period 5 cycles
  localparam logic [3:0] DUAL_HALF_LAST_LO = 4'h9;  // strap 0: half period 10 cycles

  // ----------------------------------------------------------------
  // power-up timer
  // ----------------------------------------------------------------
  localparam int unsigned PWRUP_TIME_US = 3000;
  localparam int unsigned PWRUP_CYCLES = (PWRUP_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned PWRUP_W = 20;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [NUM_DUAL-1:0] CFG_RESET = 5'h00;

  // power-up sequence of the dual-function pins
  typedef enum logic [1:0] {
    CSL_WAIT_PG,
    CSL_HOLD_LOW,
    CSL_RUN
  } csl_pwr_e;

endpackage

// ==== core/csl_top.sv ====
// clock gating for host and stoppable pci clocks, plus strap latch of dual-function pins
// assumes stop inputs and power-good come from pins and strap pads resolve the pin level
`timescale 1ns/10ps
module csl_top import csl_pkg::*; #(
  parameter int unsigned PWRUP_LIMIT = PWRUP_CYCLES
) (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // power-management pins
  input wire logic host_stop_n_i,
  input wire logic pci_stop_n_i,
  input wire logic pwr_good_i,
  // dual-function pins
  input wire logic [NUM_DUAL-1:0] dual_i,
  output logic [NUM_DUAL-1:0] dual_o,
  output logic [NUM_DUAL-1:0] dual_oe_o,
  // clock outputs
  output logic [NUM_HOST-1:0] host_clock_output_o,
  output logic mem_clk_o,
  output logic free_running_pci_clock_o,
  output logic [NUM_PCI-1:0] stoppable_pci_clock_o,
  // latched configuration
  output logic [NUM_DUAL-1:0] cfg_o
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic hstop_meta_reg, hstop_sync_reg, pstop_meta_reg, pstop_sync_reg, pg_meta_reg, pg_sync_reg;
  logic [NUM_DUAL-1:0] dual_meta_reg, dual_sync_reg;

  // pins are asynchronous to sys_clk_i; inactive stop and low power-good at reset
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hstop_meta_reg <= 1'b1;
      hstop_sync_reg <= 1'b1;
      pstop_meta_reg <= 1'b1;
      pstop_sync_reg <= 1'b1;
      pg_meta_reg <= 1'b0;
      pg_sync_reg <= 1'b0;
      dual_meta_reg <= CFG_RESET;
      dual_sync_reg <= CFG_RESET;
    end else if (clk_en_i) begin
      hstop_meta_reg <= host_stop_n_i;
      hstop_sync_reg <= hstop_meta_reg;
      pstop_meta_reg <= pci_stop_n_i;
      pstop_sync_reg <= pstop_meta_reg;
      pg_meta_reg <= pwr_good_i;
      pg_sync_reg <= pg_meta_reg;
      dual_meta_reg <= dual_i;
      dual_sync_reg <= dual_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // host clock divider and gate
  // ----------------------------------------------------------------
  logic [1:0] host_cnt_reg;
  logic host_phase_reg, host_phase_next, host_en_reg, host_en_next, host_tick;

  // enable only moves on the falling step, so the pin is already low then
  always_comb begin
    host_tick = (host_cnt_reg == HOST_HALF_LAST);
    host_phase_next = host_tick ? ~host_phase_reg : host_phase_reg;
    host_en_next = (host_tick && host_phase_reg) ? hstop_sync_reg : host_en_reg;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      host_cnt_reg <= 2'h0;
      host_phase_reg <= 1'b0;
      host_en_reg <= 1'b1;
      host_clock_output_o <= '0;
      mem_clk_o <= 1'b0;
    end else if (clk_en_i) begin
      host_cnt_reg <= host_tick ? 2'h0 : host_cnt_reg + 2'h1;
      host_phase_reg <= host_phase_next;
      host_en_reg <= host_en_next;
      host_clock_output_o <= {NUM_HOST{host_phase_next & host_en_next}};
      mem_clk_o <= host_phase_next;  // memory clock never gated
    end
  end

  // ----------------------------------------------------------------
  // pci clock divider and gate
  // ----------------------------------------------------------------
  logic [1:0] pci_cnt_reg;
  logic pci_phase_reg, pci_phase_next, pci_en_reg, pci_en_next, pci_tick;

  // stop seen by the falling step ends the clock at that edge, well inside a period
  always_comb begin
    pci_tick = (pci_cnt_reg == PCI_HALF_LAST);
    pci_phase_next = pci_tick ? ~pci_phase_reg : pci_phase_reg;
    pci_en_next = (pci_tick && pci_phase_reg) ? pstop_sync_reg : pci_en_reg;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pci_cnt_reg <= 2'h0;
      pci_phase_reg <= 1'b0;
      pci_en_reg <= 1'b1;
      stoppable_pci_clock_o <= '0;
      free_running_pci_clock_o <= 1'b0;
    end else if (clk_en_i) begin
      pci_cnt_reg <= pci_tick ? 2'h0 : pci_cnt_reg + 2'h1;
      pci_phase_reg <= pci_phase_next;
      pci_en_reg <= pci_en_next;
      stoppable_pci_clock_o <= {NUM_PCI{pci_phase_next & pci_en_next}};
      free_running_pci_clock_o <= pci_phase_next;
    end
  end

  // ----------------------------------------------------------------
  // strap latch and power-up timer
  // ----------------------------------------------------------------
  csl_pwr_e pwr_state_reg;
  logic [PWRUP_W-1:0] timer_reg;
  logic [NUM_DUAL-1:0] cfg_reg;

  // capture only leaves the wait state, so straps are taken once per power-on
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pwr_state_reg <= CSL_WAIT_PG;
      timer_reg <= '0;
      cfg_reg <= CFG_RESET;
      dual_oe_o <= '0;
    end else if (clk_en_i) begin
      case (pwr_state_reg)
        CSL_WAIT_PG: begin
          if (pg_sync_reg) begin
            cfg_reg <= dual_sync_reg;
            dual_oe_o <= '1;
            timer_reg <= '0;
            pwr_state_reg <= CSL_HOLD_LOW;
          end
        end
        CSL_HOLD_LOW: begin
          if (timer_reg == PWRUP_W'(PWRUP_LIMIT - 1)) begin
            pwr_state_reg <= CSL_RUN;
          end else begin
            timer_reg <= timer_reg + PWRUP_W'(1);
          end
        end
        CSL_RUN: begin
          pwr_state_reg <= CSL_RUN;
        end
        default: begin
          pwr_state_reg <= CSL_WAIT_PG;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_o <= CFG_RESET;
    end else if (clk_en_i) begin
      cfg_o <= cfg_reg;
    end
  end

  // ----------------------------------------------------------------
  // dual-function output dividers
  // ----------------------------------------------------------------
  // each pin runs its own divider; rate chosen by its captured strap bit
  for (genvar g = 0; g < NUM_DUAL; g++) begin : g_dual
    logic [3:0] dcnt_reg;
    logic [3:0] dlast;
    assign dlast = cfg_reg[g] ? DUAL_HALF_LAST_HI : DUAL_HALF_LAST_LO;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        dcnt_reg <= 4'h0;
        dual_o[g] <= 1'b0;
      end else if (clk_en_i) begin
        if (pwr_state_reg != CSL_RUN) begin
          dcnt_reg <= 4'h0;
          dual_o[g] <= 1'b0;  // held low until the timer ends
        end else if (dcnt_reg == dlast) begin
          dcnt_reg <= 4'h0;
          dual_o[g] <= ~dual_o[g];
        end else begin
          dcnt_reg <= dcnt_reg + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence seq_host_halted;
    (clk_en_i && !hstop_sync_reg)[*8];
  endsequence

  sequence seq_pci_halted;
    (clk_en_i && !pstop_sync_reg)[*7];
  endsequence

  AST_HOST_HALT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    seq_host_halted |-> host_clock_output_o == '0)
    else $error("host clocks still running while stopped");

  AST_HOST_PARK_LOW: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $fell(host_en_reg) |-> host_clock_output_o == '0)
    else $error("host clock gated while high");

  AST_HOST_FULL_PULSE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || !clk_en_i)
    $rose(host_clock_output_o[0]) |-> host_clock_output_o[0] [*2] ##1 !host_clock_output_o[0])
    else $error("short host clock pulse");

  AST_MEM_RUNS: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || !clk_en_i)
    $rose(mem_clk_o) |-> ##4 $rose(mem_clk_o))
    else $error("memory clock interrupted");

  AST_PCI_HALT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    seq_pci_halted |-> stoppable_pci_clock_o == '0)
    else $error("stoppable pci clocks still running while stopped");

  AST_PCI_FULL_PULSE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || !clk_en_i)
    $rose(stoppable_pci_clock_o[0]) |-> stoppable_pci_clock_o[0] [*3] ##1 !stoppable_pci_clock_o[0])
    else $error("short stoppable pci pulse");

  AST_FREE_PCI_RUNS: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i || !clk_en_i)
    $rose(free_running_pci_clock_o) |-> ##6 $rose(free_running_pci_clock_o))
    else $error("free pci clock interrupted");

  AST_STRAP_INPUT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    pwr_state_reg == CSL_WAIT_PG |-> dual_oe_o == '0)
    else $error("dual pin driven before capture");

  AST_STRAP_CAPTURE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    pwr_state_reg == CSL_WAIT_PG && pg_sync_reg && clk_en_i |=> cfg_reg == $past(dual_sync_reg))
    else $error("strap level not captured");

  AST_HOLD_LOW: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    pwr_state_reg == CSL_HOLD_LOW |-> dual_o == '0 && dual_oe_o == '1)
    else $error("dual pin not driven low after capture");

  AST_TIMER_BOUND: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    timer_reg < PWRUP_W'(PWRUP_LIMIT))
    else $error("power-up timer overran");

  AST_TIMER_EXPIRE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    pwr_state_reg == CSL_HOLD_LOW && timer_reg == PWRUP_W'(PWRUP_LIMIT - 1) && clk_en_i |=> pwr_state_reg == CSL_RUN)
    else $error("power-up timer did not end the hold");

  AST_STRAP_ONCE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    pwr_state_reg != CSL_WAIT_PG && $past(pwr_state_reg) != CSL_WAIT_PG |-> $stable(cfg_reg))
    else $error("configuration changed after capture");

endmodule

// ==== verification/csl_pm_model.sv ====
// model of the chipset power-management logic that drives the two stop pins
// assumes the bench sets the wanted stop levels; the pins follow only on free pci clock rises
`timescale 1ns/10ps
module csl_pm_model (
  // clocking
  input wire logic free_running_pci_clock_i,
  input wire logic reset_n_i,
  // wanted stop levels from the bench
  input wire logic host_req_n_i,
  input wire logic pci_req_n_i,
  // stop pins
  output logic host_stop_n_o,
  output logic pci_stop_n_o
);
  // ----------------------------------------------------------------
  // stop pins
  // ----------------------------------------------------------------
  // retimed to the free clock rise, so a change never lands in mid-period
  always_ff @(posedge free_running_pci_clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      host_stop_n_o <= 1'b1;
      pci_stop_n_o <= 1'b1;
    end else begin
      host_stop_n_o <= host_req_n_i;
      pci_stop_n_o <= pci_req_n_i;
    end
  end
endmodule

// ==== verification/clock_stop_and_strap_latch_tb.sv ====
// self-checking bench for the clock stop and strap latch block
// assumes csl_pkg and csl_top are compiled first; stimulus moves on falling clock edges
`timescale 1ns/10ps
module clock_stop_and_strap_latch_tb import csl_pkg::*;;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam logic [4:0] STRAP = 5'h16;
  localparam int PWRUP_SIM = 20;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic clk_en = 1'b1;
  logic host_req_n = 1'b1;
  logic pci_req_n = 1'b1;
  logic pwr_good = 1'b0;
  logic [4:0] dual_in = STRAP;
  logic host_stop_n, pci_stop_n, mem_clk, free_clk;
  logic [4:0] dual_out, dual_oe, cfg;
  logic [3:0] host_clk;
  logic [5:0] pci_clk;
  int error_cnt = 0;
  int comparisons = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  csl_top #(.PWRUP_LIMIT(PWRUP_SIM)) csl_top_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en),
    .host_stop_n_i(host_stop_n), .pci_stop_n_i(pci_stop_n), .pwr_good_i(pwr_good), .dual_i(dual_in),
    .dual_o(dual_out), .dual_oe_o(dual_oe), .host_clock_output_o(host_clk), .mem_clk_o(mem_clk),
    .free_running_pci_clock_o(free_clk), .stoppable_pci_clock_o(pci_clk), .cfg_o(cfg));
  csl_pm_model csl_pm_model_inst (.free_running_pci_clock_i(free_clk), .reset_n_i(reset_n_i),
    .host_req_n_i(host_req_n), .pci_req_n_i(pci_req_n), .host_stop_n_o(host_stop_n), .pci_stop_n_o(pci_stop_n));
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic close_out;
    if (error_cnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic give_up;
    error_cnt++;
    close_out();
  endtask
  // picks a watched output: 0..4 dual pins, 5 host clock, 6 stoppable pci clock
  function automatic logic sel(input int k);
    return (k < 5) ? dual_out[k] : (k == 5) ? host_clk[0] : pci_clk[0];
  endfunction
  // cycles until the output changes, then cycles it stays at the new level
  task automatic half_width(input int k, output int w, output int n);
    logic v;
    v = sel(k);
    for (w = 0; sel(k) === v && w < 80; w++) @(negedge sys_clk_i);
    if (w == 80) give_up();
    v = sel(k);
    for (n = 0; sel(k) === v && n < 40; n++) @(negedge sys_clk_i);
    if (n == 40) give_up();
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic strap_test;
    int i;
    repeat (10) @(negedge sys_clk_i);
    check(8'h00, {3'h0, dual_oe});
    pwr_good = 1'b1;
    for (i = 0; dual_oe !== 5'h1f && i < 10; i++) @(negedge sys_clk_i);
    if (i == 10) give_up();
    check(8'h00, {3'h0, dual_out});
    repeat (2) @(negedge sys_clk_i);
    check({3'h0, STRAP}, {3'h0, cfg});
    dual_in = ~STRAP;
    pwr_good = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    pwr_good = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    check({3'h0, STRAP}, {3'h0, cfg});
    check(8'h00, {3'h0, dual_out});
  endtask
  // test starts 12 cycles into the hold; first toggle 5 cycles after the hold ends; then every pin at its strap rate
  task automatic toggle_test;
    int k, w, n;
    half_width(1, w, n);
    check(8'(PWRUP_SIM + int'(DUAL_HALF_LAST_HI) + 1 - 12), 8'(w));
    for (k = 0; k < 5; k++) begin
      half_width(k, w, n);
      half_width(k, w, n);
      check(STRAP[k] ? 8'h05 : 8'h0a, 8'(n));
    end
  endtask
  // freeze of three pci half periods, so either pci clock still running would show a different level
  task automatic freeze_test;
    logic [7:0] held;
    held = {host_clk[0], mem_clk, free_clk, pci_clk[0], dual_out[3:0]};
    clk_en = 1'b0;
    repeat (9) @(negedge sys_clk_i);
    check(held, {host_clk[0], mem_clk, free_clk, pci_clk[0], dual_out[3:0]});
    check({3'h0, STRAP}, {3'h0, cfg});
    clk_en = 1'b1;
  endtask
  // stop one gated group, watch the free pci clock plus the memory or host clock run, then time the restart
  task automatic gate_test(input bit pci, input int lat, input int half);
    int i, w, n, tog_o, tog_f;
    logic po, pf;
    if (pci) pci_req_n = 1'b0;
    else host_req_n = 1'b0;
    for (i = 0; (pci ? pci_stop_n : host_stop_n) !== 1'b0 && i < 20; i++) @(negedge sys_clk_i);
    if (i == 20) give_up();
    repeat (lat) @(negedge sys_clk_i);
    tog_o = 0;
    tog_f = 0;
    po = pci ? host_clk[0] : mem_clk;
    pf = free_clk;
    repeat (30) begin
      @(negedge sys_clk_i);
      check(8'h00, pci ? {2'h0, pci_clk} : {4'h0, host_clk});
      tog_o += ((pci ? host_clk[0] : mem_clk) !== po);
      tog_f += (free_clk !== pf);
      po = pci ? host_clk[0] : mem_clk;
      pf = free_clk;
    end
    check(8'h0f, 8'(tog_o));
    check(8'h0a, 8'(tog_f));
    host_req_n = 1'b1;
    pci_req_n = 1'b1;
    for (i = 0; (pci ? pci_stop_n : host_stop_n) !== 1'b1 && i < 20; i++) @(negedge sys_clk_i);
    if (i == 20) give_up();
    half_width(pci ? 6 : 5, w, n);
    check(8'h01, {7'h0, w <= lat});
    check(8'(half), 8'(n));
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(negedge sys_clk_i);
    check(8'h00, {3'h0, dual_oe});
    check(8'h00, {2'h0, pci_clk} | {4'h0, host_clk} | {3'h0, cfg});
    reset_n_i = 1'b1;
    strap_test();
    toggle_test();
    freeze_test();
    gate_test(1'b0, 8, 2);
    gate_test(1'b1, 6, 3);
    close_out();
  end
endmodule
